// *** src/adcsq_pkg.sv ***
// Constants and types shared by the converter sequencer
`default_nettype none
package adcsq_pkg;
	localparam logic [1:0] ADDR_CTRL0 = 2'h0;
	localparam logic [1:0] ADDR_CTRL3 = 2'h1;
	localparam logic [1:0] ADDR_CHSEL = 2'h2;
	localparam logic [1:0] ADDR_STAT = 2'h3;
	localparam int LOOP_BIT = 5;
	localparam int MULTI_BIT = 4;
	localparam int MODE_HI = 3;
	localparam int MODE_LO = 2;
	localparam int GO_BIT = 1;
	localparam int DEPTH_HI = 7;
	localparam int DEPTH_LO = 6;
	localparam int TRIG_HI = 4;
	localparam int TRIG_LO = 0;
	localparam int IRQ_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int PTR_HI = 3;
	localparam int PTR_LO = 2;
	localparam int WCNT_HI = 5;
	localparam int WCNT_LO = 4;
	localparam int GA_LO = 0;
	localparam int GC_LO = 2;
	localparam int GB_LO = 4;
	localparam int GD_LO = 6;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] DEPTH_RST = 2'h0;
	localparam logic [4:0] TRIG_RST = 5'h00;
	localparam logic [7:0] CHSEL_RST = 8'h00;
	localparam logic [1:0] PTR_RST = 2'h0;
	localparam logic [1:0] WCNT_RST = 2'h0;
	localparam logic [1:0] STEP_RST = 2'h0;
	localparam logic [1:0] SEQ_TWO_GROUP_MODE = 2'h0;
	localparam logic [1:0] SEQ_FOUR_GROUP_MODE = 2'h1;
	localparam logic [1:0] SIMUL_TWO_GROUP_MODE = 2'h2;
	localparam logic [1:0] SIMUL_FOUR_GROUP_MODE = 2'h3;
	localparam logic [1:0] DEPTH_EVERY = 2'h0;
	localparam logic [1:0] DEPTH_SECOND = 2'h1;
	localparam logic [1:0] DEPTH_FOURTH = 2'h2;
	localparam logic [1:0] LAST_SINGLE = 2'h0;
	localparam logic [1:0] LAST_TWO = 2'h1;
	localparam logic [1:0] LAST_FOUR = 2'h3;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SAMPLE = 4'h2,
		ST_CONVERT = 4'h4,
		ST_WAIT = 4'h8
	} adcsq_state_type;
endpackage
`default_nettype wire

// *** src/adcsq_trig_if.sv ***
// Trigger sources, enables and start request between core and detector
`timescale 1ns/1ps
`default_nettype none
interface adcsq_trig_if;
	logic [4:0] src;
	logic [4:0] enable;
	logic hit;
	modport core (output src, output enable, input hit);
	modport det (input src, input enable, output hit);
endinterface
`default_nettype wire

// *** src/adcsq_trigger.sv ***
// Rising-edge detector and enable mask for the hardware trigger sources
`timescale 1ns/1ps
`default_nettype none

module adcsq_trigger
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	adcsq_trig_if.det trig
);

	logic [4:0] src_prev;
	logic hit;
	wire [4:0] src_rise = trig.src & ~src_prev;
	// An all-zero enable field masks every source
	wire next_hit = |(src_rise & trig.enable);

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			src_prev <= 5'h1F;
			hit <= 1'b0;
		end
		else
		begin
			src_prev <= trig.src;
			hit <= next_hit;
		end
	end

	assign trig.hit = hit;

endmodule // adcsq_trigger
`default_nettype wire

// *** src/adcsq_top.sv ***
// Auto-conversion sequencer control for a 10-bit converter with two sample-and-holds
//
// Overview of operation
// R01 - Control-0 bit 5 loops, bit 4 picks multi-group, bits 3:2 pick sequence.
// R02 - Multi, mode 00: sample and convert group A, then group B.
// R03 - Multi, mode 01: sample and convert groups A, B, C, D in order.
// R04 - Multi, mode 10: sample A and B together, convert A then B.
// R05 - Multi, mode 11: as mode 10, then sample C and D together, convert C, D.
// R06 - Simultaneous modes capture on both sample-and-holds in the same cycle.
// R07 - Single mode converts one channel; mode 00..11 picks group A..D.
// R08 - Single mode takes the channel from that group's channel select field.
// R09 - Single-shot runs once, then clears go and sets the interrupt flag.
// R10 - Software gives four-group simultaneous single-shot a nonzero acquisition time.
// R11 - Loop select 1 repeats the configured sequence instead of stopping.
// R12 - In loop operation, software go or an enabled trigger starts conversion.
// R13 - In loop operation, the depth field at control-3 bits 7:6 drives the flag.
// R14 - Software gives simultaneous loop modes a nonzero acquisition time.
// R15 - Writing 1 to the go flag still starts a conversion.
// R16 - Five trigger sources: external pin, timer five, capture one, compare two, PWM.
// R17 - Control-3 bits 4:0 enable each source; any enabled one starts.
// R18 - An enabled trigger sets go by hardware; completion clears it.
// R19 - Trigger field 00000 disables all; bit 0 external pin up to bit 4 PWM.
// R20 - Depth 00 every write, 01 2nd and 4th, 10 4th, 11 none.
// R21 - Each sequence start resets the result read pointer to 00.
// R22 - A trigger during a running sequence is ignored.
`timescale 1ns/1ps
`default_nettype none

module adcsq_top
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic external_interrupt_pin_i,
	input wire logic timer_five_i,
	input wire logic input_capture_one_i,
	input wire logic compare_unit_two_i,
	input wire logic pwm_rise_i,
	input wire logic conv_done_i,
	input wire logic result_read_i,
	output logic sh1_sample_o,
	output logic sh2_sample_o,
	output logic [1:0] sh1_chan_o,
	output logic [1:0] sh2_chan_o,
	output logic conv_start_o,
	output logic [1:0] conv_group_o,
	output logic buf_write_o,
	output logic [1:0] result_read_pointer_o,
	output logic conversion_irq_flag_o,
	output logic go_flag_o
);

	adcsq_pkg::adcsq_state_type state;
	adcsq_pkg::adcsq_state_type next_state;
	logic continuous_loop_sel;
	logic multi_channel_sel;
	logic [1:0] sequence_mode_sel;
	logic go_flag;
	logic [1:0] irq_depth_sel;
	logic [4:0] trigger_source_sel;
	logic [7:0] channel_select_reg;
	logic conversion_irq_flag;
	logic [1:0] result_read_pointer;
	logic [1:0] write_cnt;
	logic [1:0] step;
	logic [1:0] next_step;
	logic next_sh1_sample;
	logic next_sh2_sample;
	logic next_conv_start;
	logic next_buf_write;
	logic pass_end;
	logic [7:0] next_rdata;

	adcsq_trig_if trig ();

	// Bit order follows the enable field, bit 0 external pin to bit 4 PWM
	assign trig.src = {pwm_rise_i, compare_unit_two_i, input_capture_one_i,
		timer_five_i, external_interrupt_pin_i}; // [R16]
	assign trig.enable = trigger_source_sel; // [R17] [R19]

	adcsq_trigger u_trigger
	(
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.trig(trig)
	);

	wire wr_ctrl0 = reg_wr_i & (reg_addr_i == adcsq_pkg::ADDR_CTRL0);
	wire wr_ctrl3 = reg_wr_i & (reg_addr_i == adcsq_pkg::ADDR_CTRL3);
	wire wr_chsel = reg_wr_i & (reg_addr_i == adcsq_pkg::ADDR_CHSEL);
	wire wr_stat = reg_wr_i & (reg_addr_i == adcsq_pkg::ADDR_STAT);
	wire sw_go_set = wr_ctrl0 & reg_wdata_i[adcsq_pkg::GO_BIT];
	wire sw_go_clr = wr_ctrl0 & ~reg_wdata_i[adcsq_pkg::GO_BIT];
	wire idle = (state == adcsq_pkg::ST_IDLE);

	// Starts are taken only while idle, so a trigger mid-sequence is dropped
	wire start = idle & (sw_go_set | trig.hit); // [R12] [R15] [R18] [R22]

	wire simul = multi_channel_sel & sequence_mode_sel[1]; // [R04] [R05]
	wire [1:0] last_step = ~multi_channel_sel ? adcsq_pkg::LAST_SINGLE :
		(sequence_mode_sel == adcsq_pkg::SEQ_TWO_GROUP_MODE ||
		sequence_mode_sel == adcsq_pkg::SIMUL_TWO_GROUP_MODE) ?
		adcsq_pkg::LAST_TWO : adcsq_pkg::LAST_FOUR; // [R02] [R03] [R07]
	wire at_last = (step == last_step);

	// Single mode: the mode field names the group; multi mode: the step does
	wire [1:0] group = multi_channel_sel ? step : sequence_mode_sel; // [R07] [R08]

	// Simultaneous modes sample only on the first step of each pair
	wire sample_here = ~simul | ~step[0];
	wire use_sh1 = simul | ~group[0]; // [R06]
	wire use_sh2 = simul | group[0]; // [R06]

	// Groups A and C sit on the first hold, B and D on the second
	wire upper_pair = group[1];
	wire [1:0] chan_a = channel_select_reg[adcsq_pkg::GA_LO+1:adcsq_pkg::GA_LO];
	wire [1:0] chan_b = channel_select_reg[adcsq_pkg::GB_LO+1:adcsq_pkg::GB_LO];
	wire [1:0] chan_c = channel_select_reg[adcsq_pkg::GC_LO+1:adcsq_pkg::GC_LO];
	wire [1:0] chan_d = channel_select_reg[adcsq_pkg::GD_LO+1:adcsq_pkg::GD_LO];
	wire [1:0] next_sh1_chan = upper_pair ? chan_c : chan_a; // [R08]
	wire [1:0] next_sh2_chan = upper_pair ? chan_d : chan_b; // [R08]

	// Interrupt depth compares against the write number about to land
	wire depth_hit = (irq_depth_sel == adcsq_pkg::DEPTH_EVERY) |
		((irq_depth_sel == adcsq_pkg::DEPTH_SECOND) & write_cnt[0]) |
		((irq_depth_sel == adcsq_pkg::DEPTH_FOURTH) & (&write_cnt)); // [R20]

	wire loop_irq = continuous_loop_sel & next_buf_write & depth_hit; // [R13]
	wire shot_end = pass_end & ~continuous_loop_sel;
	wire stop_now = pass_end & (~continuous_loop_sel | ~go_flag | sw_go_clr);
	wire irq_set = shot_end | loop_irq; // [R09] [R13]
	wire irq_clr = wr_stat & reg_wdata_i[adcsq_pkg::IRQ_BIT];

	always_comb
	begin
		next_state = state;
		next_step = step;
		next_sh1_sample = 1'b0;
		next_sh2_sample = 1'b0;
		next_conv_start = 1'b0;
		next_buf_write = 1'b0;
		pass_end = 1'b0;
		case (state)
			adcsq_pkg::ST_IDLE:
			begin
				if (start)
				begin
					next_state = adcsq_pkg::ST_SAMPLE;
					next_step = adcsq_pkg::STEP_RST;
				end
			end
			adcsq_pkg::ST_SAMPLE:
			begin
				next_sh1_sample = sample_here & use_sh1; // [R02] [R03] [R06]
				next_sh2_sample = sample_here & use_sh2; // [R04] [R05] [R06]
				next_state = adcsq_pkg::ST_CONVERT;
			end
			adcsq_pkg::ST_CONVERT:
			begin
				next_conv_start = 1'b1;
				next_state = adcsq_pkg::ST_WAIT;
			end
			adcsq_pkg::ST_WAIT:
			begin
				if (conv_done_i)
				begin
					next_buf_write = 1'b1;
					if (!at_last)
					begin
						next_step = step + 2'h1; // [R03] [R05]
						next_state = adcsq_pkg::ST_SAMPLE;
					end
					else
					begin
						pass_end = 1'b1;
						next_step = adcsq_pkg::STEP_RST;
						// Loop keeps running until software drops go
						next_state = stop_now ? adcsq_pkg::ST_IDLE : adcsq_pkg::ST_SAMPLE; // [R09] [R11]
					end
				end
			end
			default:
			begin
				next_state = adcsq_pkg::ST_IDLE;
				next_step = adcsq_pkg::STEP_RST;
			end
		endcase
	end

	// A start outranks the hardware clear, which outranks a software clear
	wire next_go = start ? 1'b1 :
		(pass_end & stop_now) ? 1'b0 :
		sw_go_clr ? 1'b0 : go_flag; // [R09] [R18]

	// The set wins when software clears in the same cycle
	wire next_irq = irq_set | (conversion_irq_flag & ~irq_clr);

	wire [1:0] next_ptr = start ? adcsq_pkg::PTR_RST :
		result_read_i ? result_read_pointer + 2'h1 : result_read_pointer; // [R21]

	wire [1:0] next_wcnt = start ? adcsq_pkg::WCNT_RST :
		next_buf_write ? write_cnt + 2'h1 : write_cnt;

	always_comb
	begin
		next_rdata = 8'h00;
		if (!reg_rd_i)
		begin
			next_rdata = 8'h00;
		end
		else if (reg_addr_i == adcsq_pkg::ADDR_CTRL0)
		begin
			next_rdata[adcsq_pkg::LOOP_BIT] = continuous_loop_sel;
			next_rdata[adcsq_pkg::MULTI_BIT] = multi_channel_sel;
			next_rdata[adcsq_pkg::MODE_HI:adcsq_pkg::MODE_LO] = sequence_mode_sel;
			next_rdata[adcsq_pkg::GO_BIT] = go_flag;
		end
		else if (reg_addr_i == adcsq_pkg::ADDR_CTRL3)
		begin
			next_rdata[adcsq_pkg::DEPTH_HI:adcsq_pkg::DEPTH_LO] = irq_depth_sel;
			next_rdata[adcsq_pkg::TRIG_HI:adcsq_pkg::TRIG_LO] = trigger_source_sel;
		end
		else if (reg_addr_i == adcsq_pkg::ADDR_CHSEL)
		begin
			next_rdata = channel_select_reg;
		end
		else
		begin
			next_rdata[adcsq_pkg::IRQ_BIT] = conversion_irq_flag;
			next_rdata[adcsq_pkg::BUSY_BIT] = ~idle;
			next_rdata[adcsq_pkg::PTR_HI:adcsq_pkg::PTR_LO] = result_read_pointer;
			next_rdata[adcsq_pkg::WCNT_HI:adcsq_pkg::WCNT_LO] = write_cnt;
		end
	end

	// Mode bits change freely; software should hold them while a sequence runs
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			continuous_loop_sel <= 1'b0;
			multi_channel_sel <= 1'b0;
			sequence_mode_sel <= adcsq_pkg::MODE_RST;
		end
		else if (wr_ctrl0)
		begin
			continuous_loop_sel <= reg_wdata_i[adcsq_pkg::LOOP_BIT]; // [R01]
			multi_channel_sel <= reg_wdata_i[adcsq_pkg::MULTI_BIT]; // [R01]
			sequence_mode_sel <= reg_wdata_i[adcsq_pkg::MODE_HI:adcsq_pkg::MODE_LO]; // [R01]
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_depth_sel <= adcsq_pkg::DEPTH_RST;
			trigger_source_sel <= adcsq_pkg::TRIG_RST;
		end
		else if (wr_ctrl3)
		begin
			irq_depth_sel <= reg_wdata_i[adcsq_pkg::DEPTH_HI:adcsq_pkg::DEPTH_LO]; // [R13]
			trigger_source_sel <= reg_wdata_i[adcsq_pkg::TRIG_HI:adcsq_pkg::TRIG_LO]; // [R17]
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			channel_select_reg <= adcsq_pkg::CHSEL_RST;
		end
		else if (wr_chsel)
		begin
			channel_select_reg <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= adcsq_pkg::ST_IDLE;
			step <= adcsq_pkg::STEP_RST;
			go_flag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
			go_flag <= next_go;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			conversion_irq_flag <= 1'b0;
			result_read_pointer <= adcsq_pkg::PTR_RST;
			write_cnt <= adcsq_pkg::WCNT_RST;
		end
		else
		begin
			conversion_irq_flag <= next_irq;
			result_read_pointer <= next_ptr;
			write_cnt <= next_wcnt;
		end
	end

	// Channel outputs only move on a sample so a held value is never disturbed
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sh1_chan_o <= 2'h0;
			sh2_chan_o <= 2'h0;
		end
		else
		begin
			if (next_sh1_sample)
			begin
				sh1_chan_o <= next_sh1_chan;
			end
			if (next_sh2_sample)
			begin
				sh2_chan_o <= next_sh2_chan;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sh1_sample_o <= 1'b0;
			sh2_sample_o <= 1'b0;
			conv_start_o <= 1'b0;
			conv_group_o <= 2'h0;
			buf_write_o <= 1'b0;
		end
		else
		begin
			sh1_sample_o <= next_sh1_sample;
			sh2_sample_o <= next_sh2_sample;
			conv_start_o <= next_conv_start;
			if (next_conv_start)
			begin
				conv_group_o <= group; // [R02] [R03] [R04] [R05]
			end
			buf_write_o <= next_buf_write;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			reg_rdata_o <= 8'h00;
			result_read_pointer_o <= adcsq_pkg::PTR_RST;
			conversion_irq_flag_o <= 1'b0;
			go_flag_o <= 1'b0;
		end
		else
		begin
			reg_rdata_o <= next_rdata;
			result_read_pointer_o <= next_ptr;
			conversion_irq_flag_o <= next_irq;
			go_flag_o <= next_go;
		end
	end

endmodule // adcsq_top
`default_nettype wire

// *** sim/adcsq_properties.sv ***
// Port timing properties of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_properties
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic conv_done_i,
	input wire logic result_read_i,
	input wire logic sh1_sample_o,
	input wire logic sh2_sample_o,
	input wire logic conv_start_o,
	input wire logic [1:0] conv_group_o,
	input wire logic buf_write_o,
	input wire logic [1:0] result_read_pointer_o,
	input wire logic conversion_irq_flag_o,
	input wire logic go_flag_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	sample_then_convert_a:
	assert property ((sh1_sample_o || sh2_sample_o) |=> conv_start_o)
	else $error("no conversion after sample");
	simul_pair_group_a:
	assert property (sh1_sample_o && sh2_sample_o |=> conv_start_o && !conv_group_o[0])
	else $error("paired sample not on group A or C");
	write_needs_done_a:
	assert property (buf_write_o |-> $past(conv_done_i))
	else $error("result write without converter done");
	// Software may also drop go by writing it 0; otherwise only a final write clears it
	done_clears_go_a:
	assert property ($fell(go_flag_o) |-> buf_write_o || ($past(reg_wr_i) &&
		$past(reg_addr_i) == adcsq_pkg::ADDR_CTRL0 && !$past(reg_wdata_i[adcsq_pkg::GO_BIT])))
	else $error("go cleared without a result write");
	start_samples_a:
	assert property ($rose(go_flag_o) |=> sh1_sample_o || sh2_sample_o)
	else $error("start not followed by a sample");
	start_ptr_zero_a:
	assert property ($rose(go_flag_o) |-> result_read_pointer_o == 2'h0)
	else $error("read pointer not zero at start");
	ptr_advance_a:
	assert property (result_read_i ##1 !$rose(go_flag_o) |-> result_read_pointer_o == $past(result_read_pointer_o) + 2'h1)
	else $error("read pointer did not advance");
	irq_on_write_a:
	assert property ($rose(conversion_irq_flag_o) |-> buf_write_o)
	else $error("interrupt flag set without a write");
	cover property (sh1_sample_o && sh2_sample_o);
	cover property ($rose(conversion_irq_flag_o));
	cover property ($fell(go_flag_o));
endmodule // adcsq_properties
bind adcsq_top adcsq_properties u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .conv_done_i(conv_done_i),
	.result_read_i(result_read_i), .sh1_sample_o(sh1_sample_o), .sh2_sample_o(sh2_sample_o),
	.conv_start_o(conv_start_o), .conv_group_o(conv_group_o), .buf_write_o(buf_write_o),
	.result_read_pointer_o(result_read_pointer_o), .conversion_irq_flag_o(conversion_irq_flag_o),
	.go_flag_o(go_flag_o));
`default_nettype wire

// *** sim/adcsq_conv_model.sv ***
// Converter model: answers each conversion start after a set delay
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic conv_start_i,
	input wire logic [3:0] lat_i,
	output logic conv_done_o
);
	logic [4:0] cnt;
	// Delay zero answers two cycles after the start pulse; larger values keep the sequence busy
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt <= 5'h00;
			conv_done_o <= 1'b0;
		end
		else
		begin
			conv_done_o <= (cnt == 5'h01);
			if (conv_start_i)
				cnt <= {1'b0, lat_i} + 5'h01;
			else if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
		end
	end
endmodule // adcsq_conv_model
`default_nettype wire

// *** sim/adcsq_tb_top.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_tb_top;
	localparam logic [1:0] CH [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
	logic mclk_i, arst_n_i, reg_wr_i, reg_rd_i, conv_done_i, result_read_i;
	logic sh1_sample_o, sh2_sample_o, conv_start_o, buf_write_o, conversion_irq_flag_o, go_flag_o;
	logic [1:0] reg_addr_i, sh1_chan_o, sh2_chan_o, conv_group_o, result_read_pointer_o;
	logic [7:0] reg_wdata_i, reg_rdata_o, v;
	logic [4:0] src;
	logic [3:0] lat;
	logic [1:0] cq[$];
	logic [3:0] sq[$];
	int fail_count, tests_run, nwr, first, cyc;
	adcsq_top u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .external_interrupt_pin_i(src[0]),
		.timer_five_i(src[1]), .input_capture_one_i(src[2]), .compare_unit_two_i(src[3]), .pwm_rise_i(src[4]),
		.conv_done_i(conv_done_i), .result_read_i(result_read_i), .sh1_sample_o(sh1_sample_o),
		.sh2_sample_o(sh2_sample_o), .sh1_chan_o(sh1_chan_o), .sh2_chan_o(sh2_chan_o), .conv_start_o(conv_start_o),
		.conv_group_o(conv_group_o), .buf_write_o(buf_write_o), .result_read_pointer_o(result_read_pointer_o),
		.conversion_irq_flag_o(conversion_irq_flag_o), .go_flag_o(go_flag_o));
	adcsq_conv_model u_conv (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .conv_start_i(conv_start_o), .lat_i(lat),
		.conv_done_o(conv_done_i));
	always #10 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		if (conv_start_o)
			cq.push_back(conv_group_o);
		if (sh1_sample_o || sh2_sample_o)
			sq.push_back({sh2_sample_o, sh1_sample_o, sh1_sample_o ? sh1_chan_o : sh2_chan_o});
		if (buf_write_o)
			nwr++;
		if (buf_write_o && conversion_irq_flag_o && first == 0)
			first = nwr;
	end
	// Whole run needs under a thousand cycles
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		d = reg_rdata_o;
	endtask
	task automatic pulse(input logic [4:0] p);
		@(posedge mclk_i);
		src <= p;
		@(posedge mclk_i);
		src <= 5'h00;
	endtask
	task automatic wait_go(input logic e);
		int n;
		n = 0;
		@(negedge mclk_i);
		while (n < 400 && go_flag_o !== e)
		begin
			@(negedge mclk_i);
			n++;
		end
		chk("go_flag", {7'h0, e}, {7'h0, go_flag_o});
	endtask
	task automatic t_regs();
		for (int a = 0; a < 4; a++)
		begin
			rd(2'(a), v);
			chk("reset_reg", 8'h00, v);
		end
		wr(adcsq_pkg::ADDR_CTRL3, 8'hFF);
		rd(adcsq_pkg::ADDR_CTRL3, v);
		chk("ctrl3", 8'hDF, v);
		$display("register test done");
	endtask
	task automatic t_modes();
		logic [1:0] g;
		int j;
		wr(adcsq_pkg::ADDR_CHSEL, 8'hE4);
		for (int i = 0; i < 8; i++)
		begin
			cq.delete();
			sq.delete();
			j = 0;
			// No acquisition time is modelled; a sample leads each conversion except the second of a simultaneous pair
			wr(adcsq_pkg::ADDR_CTRL0, {3'h0, i[2:0], 2'h2});
			wait_go(1'b0);
			chk("convs", (i[2] && i[0]) ? 8'h04 : (i[2] ? 8'h02 : 8'h01), 8'(cq.size()));
			for (int k = 0; k < cq.size(); k++)
			begin
				g = i[2] ? 2'(k) : i[1:0];
				chk("group", {6'h0, g}, {6'h0, cq[k]});
				if (!(i[2] && i[1] && g[0]))
				begin
					chk("sample", {4'h0, i[2] && i[1] ? 2'h3 : (g[0] ? 2'h2 : 2'h1), CH[g]}, {4'h0, sq[j]});
					j++;
				end
			end
			chk("samples", 8'(j), 8'(sq.size()));
			chk("irq", 8'h01, {7'h0, conversion_irq_flag_o});
			wr(adcsq_pkg::ADDR_STAT, 8'h01);
		end
		$display("mode test done");
	endtask
	task automatic t_trig();
		logic [4:0] en;
		lat <= 4'hC;
		wr(adcsq_pkg::ADDR_CTRL0, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			en = (i < 5) ? 5'(1 << i) : 5'h00;
			wr(adcsq_pkg::ADDR_CTRL3, {3'h0, en});
			cq.delete();
			pulse(~en);
			repeat (4) @(negedge mclk_i);
			chk("go_masked", 8'h00, {7'h0, go_flag_o});
			if (i < 5)
			begin
				pulse(en);
				wait_go(1'b1);
				pulse(en);
				wait_go(1'b0);
				chk("conv_once", 8'h01, 8'(cq.size()));
			end
		end
		lat <= 4'h2;
		$display("trigger test done");
	endtask
	task automatic t_ptr();
		@(posedge mclk_i);
		result_read_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		result_read_i <= 1'b0;
		@(negedge mclk_i);
		chk("ptr", 8'h03, {6'h0, result_read_pointer_o});
		wr(adcsq_pkg::ADDR_CTRL0, 8'h02);
		@(negedge mclk_i);
		chk("ptr_start", 8'h00, {6'h0, result_read_pointer_o});
		wait_go(1'b0);
		$display("pointer test done");
	endtask
	task automatic t_loop();
		int n;
		for (int d = 0; d < 4; d++)
		begin
			wr(adcsq_pkg::ADDR_STAT, 8'h01);
			// Odd depths run the simultaneous loop and start it from the external pin
			wr(adcsq_pkg::ADDR_CTRL3, {d[1:0], 1'b0, 4'h0, d[0]});
			nwr = 0;
			first = 0;
			wr(adcsq_pkg::ADDR_CTRL0, {2'h0, 2'h3, d[0], 1'b1, ~d[0], 1'b0});
			if (d[0])
				pulse(5'h01);
			n = 0;
			while (n < 600 && nwr < 8)
			begin
				@(negedge mclk_i);
				n++;
			end
			chk("loop_writes", 8'h08, 8'(nwr));
			chk("irq_depth", d == 3 ? 8'h00 : 8'(1 << d), 8'(first));
			wr(adcsq_pkg::ADDR_CTRL0, {2'h0, 2'h3, d[0], 1'b1, 2'h0});
			wait_go(1'b0);
			// Dropping go only ends the loop once the running pass is through
			n = 0;
			v = 8'h02;
			while (n < 100 && v[adcsq_pkg::BUSY_BIT])
			begin
				rd(adcsq_pkg::ADDR_STAT, v);
				n++;
			end
			chk("loop_stopped", 8'h00, {7'h0, v[adcsq_pkg::BUSY_BIT]});
			chk("whole_pass", 8'h00, 8'(nwr % 4));
		end
		$display("loop test done");
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		mclk_i = 1'b0;
		arst_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 2'h0;
		reg_wdata_i = 8'h00;
		result_read_i = 1'b0;
		src = 5'h00;
		lat = 4'h2;
		repeat (16) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_modes();
		t_trig();
		t_ptr();
		t_loop();
		give_verdict();
	end
endmodule // adcsq_tb_top
`default_nettype wire
